// file: pkg/idps_map.svh
`ifndef IDPS_MAP_SVH
`define IDPS_MAP_SVH

// Register offsets
`define IDPS_STATUS_ADDR   8'h11
`define IDPS_POWER_ADDR    8'h12

// Status bit positions
`define IDPS_ST_HSYNC      7
`define IDPS_ST_VSYNC      6
`define IDPS_ST_GREEN      5
`define IDPS_ST_LINKCLK    4

// Power control bit positions
`define IDPS_PC_POWERUP    0
`define IDPS_PC_SELECT     1
`define IDPS_PC_OVERRIDE   2

// Power control reset: powered, automatic, select analog
`define IDPS_PC_RESET      3'h1

// Data-enable pulses needed for detection
`define IDPS_DE_TARGET     6'h20

// Activity timeout and clock rate
`define IDPS_TIMEOUT_MS    100
`define IDPS_CLK_KHZ       250000
// Reload margin covers the detector and output register stages
`define IDPS_TIMEOUT_SLACK 3

`endif

// file: pkg/idps_pkg.sv
`default_nettype none

package idps_pkg;

  typedef enum logic [1:0] {
    IDPS_ABS_PD  = 2'b00,
    IDPS_SEEK    = 2'b01,
    IDPS_ANALOG  = 2'b10,
    IDPS_DIGITAL = 2'b11
  } idps_mode_e;

  // Power enables of the circuit blocks
  typedef struct packed {
    logic serialBus;
    logic analogIf;
    logic digitalIf;
    logic clkDetect;
    logic analogActDetect;
    logic hsyncDetect;
    logic greenSlicer;
    logic outputs;
    logic bandgap;
  } idps_power_s;

  // Software controls held in the power control register
  typedef struct packed {
    logic interfaceOverride;
    logic interfaceSelect;
    logic powerUp;
  } idps_ctrl_s;

  // Register port request
  typedef struct packed {
    logic       wrEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } idps_reg_req_s;

endpackage

`default_nettype wire

// file: logic/idps_detect_power.sv
`timescale 1ns/1ps
`default_nettype none
`include "idps_map.svh"

// What this block does
// - Watch hsync, vsync, green sync; report at status bits 7, 6, 5.
// - Clear an analog sync detect within 100 ms of the sync stopping.
// - Link clock detector always runs; report it at status bit 4.
// - Clear link clock detect within 100 ms of the clock stopping.
// - Data-enable detected after 32 pulses, counted only when digital powered.
// - Sync-detect output is data-enable detect OR hsync detect.
// - Override 0 selects automatically; override 1 lets select bit decide.
// - Only one interface active; the unused one is powered down.
// - Automatic, nothing detected: both interfaces off, sync-detect forced low.
// - Power-down beats override, override beats automatic detection.
// - Digital active keeps bandgap and hsync detect powered.
// - Analog active keeps link clock detect powered.
// - Automatic, one interface detected: that one active, the other off.
// - Automatic, both detected: select 0 gives analog, 1 gives digital.
// - Power control bit 0 low means absolute power-down, serial bus only.
// - Seek mode keeps bus, clock detect, activity detect, slicer, bandgap.
// - Analog detect is OR of status bits 7..5; digital detect is bit 4.
// - Interface-on modes power their interface, detectors, outputs, bandgap.
module idps_detect_power
  import idps_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC =
    `IDPS_TIMEOUT_MS * `IDPS_CLK_KHZ
)
(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // Sampled activity inputs
  input  wire logic          hsyncIn,
  input  wire logic          vsyncIn,
  input  wire logic          greenSyncIn,
  input  wire logic          linkClkIn,
  input  wire logic          dataEnableIn,
  // Register port from the serial bus
  input  wire idps_reg_req_s regReq,
  output logic [7:0]         rdData_r,
  // Power state and pin
  output idps_mode_e         mode_r,
  output idps_power_s        power_r,
  output logic               activityDetectOut_r
);

  localparam int unsigned RELOAD = TIMEOUT_CYC - `IDPS_TIMEOUT_SLACK;

  function automatic idps_power_s power_of(input idps_mode_e m);
    idps_power_s p;
    p = '0;
    p.serialBus = 1'b1;
    case (m)
      IDPS_SEEK:
      begin
        p.clkDetect       = 1'b1;
        p.analogActDetect = 1'b1;
        p.hsyncDetect     = 1'b1;
        p.greenSlicer     = 1'b1;
        p.bandgap         = 1'b1;
      end
      IDPS_ANALOG:
      begin
        p.analogIf        = 1'b1;
        p.analogActDetect = 1'b1;
        p.hsyncDetect     = 1'b1;
        p.clkDetect       = 1'b1;
        p.greenSlicer     = 1'b1;
        p.outputs         = 1'b1;
        p.bandgap         = 1'b1;
      end
      IDPS_DIGITAL:
      begin
        p.digitalIf       = 1'b1;
        p.clkDetect       = 1'b1;
        p.analogActDetect = 1'b1;
        p.hsyncDetect     = 1'b1;
        p.greenSlicer     = 1'b1;
        p.outputs         = 1'b1;
        p.bandgap         = 1'b1;
      end
      default: p.serialBus = 1'b1;
    endcase
    return p;
  endfunction

  // ************************************
  // Activity detectors
  // ************************************
  logic [3:0] actIn;
  logic [3:0] prev_r;
  logic [3:0] det_r;
  logic [3:0] edgeSeen;
  logic [24:0] cnt_r [4];

  assign actIn = {hsyncIn, vsyncIn, greenSyncIn, linkClkIn};

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gDet
      logic [24:0] cnt_nxt;
      logic        det_nxt;
      assign edgeSeen[g] = actIn[g] ^ prev_r[g];
      always_comb
      begin
        cnt_nxt = cnt_r[g];
        det_nxt = det_r[g];
        if (edgeSeen[g])
        begin
          cnt_nxt = RELOAD[24:0];
          det_nxt = 1'b1;
        end
        else if (cnt_r[g] != 25'h0)
          cnt_nxt = cnt_r[g] - 25'h1;
        else
          det_nxt = 1'b0;
      end
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          cnt_r[g]  <= 25'h0;
          det_r[g]  <= 1'b0;
          prev_r[g] <= 1'b0;
        end
        else
        begin
          cnt_r[g]  <= cnt_nxt;
          det_r[g]  <= det_nxt;
          prev_r[g] <= actIn[g];
        end
      end
    end
  endgenerate

  logic hsDet;
  logic clkDet;
  logic anaDet;
  assign hsDet  = det_r[3];
  assign clkDet = det_r[0];
  assign anaDet = |det_r[3:1];

  // ************************************
  // Data-enable counter
  // ************************************
  logic [5:0] deCnt_r;
  logic [5:0] deCnt_nxt;
  logic       deDet_r;
  logic       deDet_nxt;
  logic       dePrev_r;

  always_comb
  begin
    deCnt_nxt = deCnt_r;
    deDet_nxt = deDet_r;
    // clear when off or clock lost
    if (!power_r.digitalIf || !clkDet)
    begin
      deCnt_nxt = 6'h0;
      deDet_nxt = 1'b0;
    end
    else if (dataEnableIn && !dePrev_r && !deDet_r)
    begin
      deCnt_nxt = deCnt_r + 6'h1;
      if (deCnt_nxt == `IDPS_DE_TARGET)
        deDet_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      deCnt_r  <= 6'h0;
      deDet_r  <= 1'b0;
      dePrev_r <= 1'b0;
    end
    else
    begin
      deCnt_r  <= deCnt_nxt;
      deDet_r  <= deDet_nxt;
      dePrev_r <= dataEnableIn;
    end
  end

  // ************************************
  // Registers
  // ************************************
  idps_ctrl_s ctrl_r;
  idps_ctrl_s ctrl_nxt;
  logic [7:0] status;
  logic [7:0] rdData_nxt;

  always_comb
  begin
    status = 8'h0;
    status[`IDPS_ST_HSYNC]   = det_r[3];
    status[`IDPS_ST_VSYNC]   = det_r[2];
    status[`IDPS_ST_GREEN]   = det_r[1];
    status[`IDPS_ST_LINKCLK] = det_r[0];
  end

  always_comb
  begin
    ctrl_nxt   = ctrl_r;
    rdData_nxt = 8'h0;
    if (regReq.wrEn && regReq.addr == `IDPS_POWER_ADDR)
    begin
      ctrl_nxt.powerUp           = regReq.wrData[`IDPS_PC_POWERUP];
      ctrl_nxt.interfaceSelect   = regReq.wrData[`IDPS_PC_SELECT];
      ctrl_nxt.interfaceOverride = regReq.wrData[`IDPS_PC_OVERRIDE];
    end
    if (regReq.addr == `IDPS_STATUS_ADDR)
      rdData_nxt = status;
    else if (regReq.addr == `IDPS_POWER_ADDR)
    begin
      rdData_nxt[`IDPS_PC_POWERUP]  = ctrl_r.powerUp;
      rdData_nxt[`IDPS_PC_SELECT]   = ctrl_r.interfaceSelect;
      rdData_nxt[`IDPS_PC_OVERRIDE] = ctrl_r.interfaceOverride;
    end
  end

  // ************************************
  // Power mode
  // ************************************
  idps_mode_e  mode_nxt;
  idps_power_s power_nxt;
  logic        syncOut_nxt;
  idps_mode_e  selMode;

  assign selMode = ctrl_r.interfaceSelect ? IDPS_DIGITAL : IDPS_ANALOG;

  always_comb
  begin
    if (!ctrl_r.powerUp)
      mode_nxt = IDPS_ABS_PD;
    else if (ctrl_r.interfaceOverride)
      mode_nxt = selMode;
    else
    begin
      case ({anaDet, clkDet})
        2'b00:   mode_nxt = IDPS_SEEK;
        2'b01:   mode_nxt = IDPS_DIGITAL;
        2'b10:   mode_nxt = IDPS_ANALOG;
        default: mode_nxt = selMode;
      endcase
    end
    syncOut_nxt = (mode_nxt != IDPS_SEEK) && (deDet_r || hsDet);
    power_nxt   = power_of(mode_nxt);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl_r              <= `IDPS_PC_RESET;
      rdData_r            <= 8'h0;
      mode_r              <= IDPS_SEEK;
      power_r             <= power_of(IDPS_SEEK);
      activityDetectOut_r <= 1'b0;
    end
    else
    begin
      ctrl_r              <= ctrl_nxt;
      rdData_r            <= rdData_nxt;
      mode_r              <= mode_nxt;
      power_r             <= power_nxt;
      activityDetectOut_r <= syncOut_nxt;
    end
  end

  // ************************************
  // Assertions
  // ************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  status_read_a: assert property (
    regReq.addr == `IDPS_STATUS_ADDR |=> rdData_r == $past(status))
    else $error("Status read mismatch");
  hsync_clear_a: assert property (
    det_r[3] && cnt_r[3] == 25'h0 && !edgeSeen[3] |=> !det_r[3])
    else $error("Hsync detect not cleared");
  clk_clear_a: assert property (
    det_r[0] && cnt_r[0] == 25'h0 && !edgeSeen[0] |=> !det_r[0])
    else $error("Clock detect not cleared");
  clk_runs_a: assert property (
    edgeSeen[0] |=> det_r[0])
    else $error("Clock detect not set");
  de_count_a: assert property (
    $rose(deDet_r) |-> $past(deCnt_r) == (`IDPS_DE_TARGET - 6'h1)
    && $past(power_r.digitalIf))
    else $error("Data-enable detect early");
  de_clear_a: assert property (
    !power_r.digitalIf |=> deCnt_r == 6'h0 && !deDet_r)
    else $error("Data-enable count kept");
  sync_pin_a: assert property (
    mode_r != IDPS_SEEK |->
    activityDetectOut_r == ($past(deDet_r) || $past(hsDet)))
    else $error("Sync-detect pin wrong");
  seek_a: assert property (
    ctrl_r.powerUp && !ctrl_r.interfaceOverride && !anaDet && !clkDet
    |=> mode_r == IDPS_SEEK && !activityDetectOut_r && !power_r.analogIf
    && !power_r.digitalIf)
    else $error("Seek mode not entered");
  pd_first_a: assert property (
    !ctrl_r.powerUp |=> mode_r == IDPS_ABS_PD && power_r == 9'h100)
    else $error("Power-down not obeyed");
  override_a: assert property (
    ctrl_r.powerUp && ctrl_r.interfaceOverride |=> mode_r == $past(selMode))
    else $error("Override not obeyed");
  one_if_a: assert property (
    !(power_r.analogIf && power_r.digitalIf))
    else $error("Both interfaces on");
  dig_keep_a: assert property (
    power_r.digitalIf |-> power_r.bandgap && power_r.hsyncDetect)
    else $error("Digital mode lost bandgap");
  ana_keep_a: assert property (
    power_r.analogIf |-> power_r.clkDetect && !power_r.digitalIf)
    else $error("Analog mode lost clock detect");

endmodule

`default_nettype wire

// file: tb/idps_source_model.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************
// Graphics source driving the activity lines
// ************************************************
module idps_source_model
(
  // Clock
  input  wire logic       clock,
  // Line enables: hsync, vsync, green, link clock
  input  wire logic [3:0] lineEn,
  // Activity lines
  output var logic        hsync,
  output var logic        vsync,
  output var logic        green,
  output var logic        linkClk,
  output var logic        de
);
  logic [2:0] phase;

  initial
  begin
    phase = 3'h0;
    {hsync, vsync, green, linkClk, de} = 5'h00;
  end

  // Disabled lines hold still, as an unplugged cable would
  always @(posedge clock)
  begin
    phase <= phase + 3'h1;
    if (phase == 3'h7)
    begin
      hsync   <= hsync ^ lineEn[3];
      vsync   <= vsync ^ lineEn[2];
      green   <= green ^ lineEn[1];
      linkClk <= linkClk ^ lineEn[0];
    end
  end

  // One rising edge of data enable per pulse
  task automatic deBurst(input int n);
    repeat (n)
    begin
      @(posedge clock) de <= 1'b1;
      @(posedge clock) de <= 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// file: tb/idps_detect_power_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module idps_detect_power_tb_top
  import idps_pkg::*;
;
  // ************************************************
  // Setup
  // ************************************************
  // Short timeout keeps the run small
  localparam int TO = 64;
  localparam logic [8:0] PSEEK = 9'h13d;
  localparam logic [8:0] PABS  = 9'h100;
  localparam logic [8:0] PDIG  = 9'h15f;
  localparam logic [8:0] MDIG  = 9'h1df;
  localparam logic [8:0] PANA  = 9'h1a7;
  localparam logic [8:0] MANA  = 9'h1e7;
  localparam logic [8:0] MALL  = 9'h1ff;

  logic          clock  = 1'b0;
  logic          rst    = 1'b1;
  logic [3:0]    lineEn = 4'h0;
  idps_reg_req_s regReq = '0;
  logic          h;
  logic          v;
  logic          g;
  logic          l;
  logic          de;
  logic [7:0]    rdData;
  idps_mode_e    mode;
  idps_power_s   power;
  logic          pin;
  int            errCount = 0;
  int            testsRun = 0;

  always #2 clock = ~clock;

  idps_detect_power #(.TIMEOUT_CYC(TO)) dut_u
  (
    .clock(clock), .rst(rst), .hsyncIn(h), .vsyncIn(v), .greenSyncIn(g),
    .linkClkIn(l), .dataEnableIn(de), .regReq(regReq), .rdData_r(rdData),
    .mode_r(mode), .power_r(power), .activityDetectOut_r(pin)
  );

  idps_source_model src_u
  (
    .clock(clock), .lineEn(lineEn), .hsync(h), .vsync(v), .green(g),
    .linkClk(l), .de(de)
  );

  // ************************************************
  // Tasks
  // ************************************************
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmpReg(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      errCount++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask

  task automatic cmpState(input logic [11:0] got, exp, msk);
    testsRun++;
    if ((got & msk) !== (exp & msk))
    begin
      errCount++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic ln(input logic [3:0] e);
    @(posedge clock);
    lineEn <= e;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regReq <= '{wrEn: 1'b1, addr: a, wrData: d};
    @(posedge clock);
    regReq.wrEn <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    regReq.addr <= a;
    @(posedge clock);
    #1 cmpReg(rdData, e);
  endtask

  task automatic st(input idps_mode_e m, input logic [8:0] p, pm,
                    input logic s);
    wt(2);
    #1 cmpState({mode, power, pin}, {m, p, s}, {2'b11, pm, 1'b1});
  endtask

  // ************************************************
  // Tests
  // ************************************************
  initial
  begin
    #200000;
    errCount++;
    conclude();
  end

  initial
  begin
    wt(6);
    rst <= 1'b0;
    rdChk(8'h12, 8'h01);
    rdChk(8'h11, 8'h00);
    st(IDPS_SEEK, PSEEK, MALL, 1'b0);
    wr(8'h11, 8'hff);
    rdChk(8'h11, 8'h00);
    rdChk(8'h13, 8'h00);
    wr(8'h12, 8'hff);
    rdChk(8'h12, 8'h07);
    wr(8'h12, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      ln(4'h8 >> i);
      wt(20);
      rdChk(8'h11, 8'h80 >> i);
      st(IDPS_ANALOG, PANA, MANA, i == 0);
      ln(4'h0);
      wt(TO + 4);
      rdChk(8'h11, 8'h00);
      st(IDPS_SEEK, PSEEK, MALL, 1'b0);
    end
    ln(4'h1);
    wt(20);
    rdChk(8'h11, 8'h10);
    st(IDPS_DIGITAL, PDIG, MDIG, 1'b0);
    src_u.deBurst(31);
    st(IDPS_DIGITAL, PDIG, MDIG, 1'b0);
    src_u.deBurst(1);
    st(IDPS_DIGITAL, PDIG, MDIG, 1'b1);
    ln(4'h0);
    wt(TO + 4);
    rdChk(8'h11, 8'h00);
    st(IDPS_SEEK, PSEEK, MALL, 1'b0);
    ln(4'h1);
    wt(20);
    src_u.deBurst(31);
    st(IDPS_DIGITAL, PDIG, MDIG, 1'b0);
    ln(4'h5);
    wt(20);
    st(IDPS_ANALOG, PANA, MANA, 1'b0);
    wr(8'h12, 8'h03);
    st(IDPS_DIGITAL, PDIG, MDIG, 1'b0);
    wr(8'h12, 8'h05);
    st(IDPS_ANALOG, PANA, MANA, 1'b0);
    src_u.deBurst(32);
    st(IDPS_ANALOG, PANA, MANA, 1'b0);
    ln(4'h0);
    wt(TO + 4);
    st(IDPS_ANALOG, PANA, MANA, 1'b0);
    wr(8'h12, 8'h07);
    st(IDPS_DIGITAL, PDIG, MDIG, 1'b0);
    ln(4'h1);
    wr(8'h12, 8'h06);
    wt(20);
    rdChk(8'h11, 8'h10);
    st(IDPS_ABS_PD, PABS, MALL, 1'b0);
    conclude();
  end
endmodule

`default_nettype wire
